// [src/mailbox_interrupt_queue_ctrl.sv]
module mailbox_interrupt_queue_ctrl #(
  parameter int LFIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave, host registers
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // local microprocessor bus
  input wire logic loc_sel,
  input wire logic loc_we,
  input wire logic [4:0] loc_addr,
  input wire logic [31:0] loc_wdata,
  output logic [31:0] loc_rdata,
  // vector sources (channel, port, command)
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [31:0] src_vector,
  input wire logic [3:0] src_queue,
  // receive buffer events
  input wire logic rx_drop_pulse,
  input wire logic rx_data_over_th,
  input wire logic rx_action_over_th,
  // system memory writes for the queues
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [31:0] mem_wr_addr,
  output logic [31:0] mem_wr_data,
  // interrupt pins
  input wire logic local_irq_in,
  output logic local_irq_out,
  output logic pci_irq_out
);
  import mbx_irq_pkg::*;

  localparam int LPW = $clog2(LFIFO_DEPTH);

  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_BUSY = 2'b10
  } wr_state_e;

  wr_state_e wr_state;
  logic aw_held, w_held, wr_do, strb_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] rd_data;
  logic rd_err, wr_err;
  logic [5:0] general_config_one;
  logic [8:0] gstat, qmask, hpmask;
  logic [4:0] sys_mask, sys_pend, sys_ev, sys_take;
  logic [15:0] drop_cnt, drop_th;
  logic [31:0] h2l [MBX_REGS];
  logic [31:0] l2h [MBX_REGS];
  logic [31:0] q_start [NUM_QUEUES];
  logic [15:0] q_len [NUM_RING_QUEUES];
  logic [15:0] q_wptr [NUM_QUEUES];
  logic [15:0] mb_system_vector_a, pb_system_vector_a;
  logic [31:0] lf_mem [LFIFO_DEPTH];
  logic [LPW-1:0] lf_wp, lf_rp;
  logic [LPW:0] lf_cnt;
  logic lf_push, lf_pop;
  logic local_irq_out_s1, local_irq_out_s2;
  logic data_th_d, act_th_d;
  logic [3:0] cur_q;
  logic [3:0] ext_q;
  logic take_src, take_sys;
  logic [31:0] sys_vec;
  logic [3:0] hidx;
  logic [2:0] midx;
  logic loc_wr_l2h_status;

  // write path: address and data may arrive in either order
  assign wr_do = aw_held && w_held && !s_bvalid;
  assign strb_full = (w_strb == 4'hF);
  assign hidx = 4'((aw_addr - OFS_QSTART) >> 2);
  assign midx = aw_addr[4:2];
  always_comb begin
    wr_err = 1'b0;
    if (!strb_full) begin
      wr_err = 1'b1;
    end else if (aw_addr[1:0] != 2'h0) begin
      wr_err = 1'b1;
    end else if (aw_addr >= 8'hC0 || (aw_addr >= 8'h84 && aw_addr < OFS_QLEN) || aw_addr == OFS_GSTAT) begin
      wr_err = 1'b1;
    end else if (aw_addr >= OFS_L2H && aw_addr < OFS_QSTART) begin
      wr_err = 1'b1; // local-to-host page is read-only for the host
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
        s_awready <= 1'b0;
      end else if (!aw_held && !s_bvalid) begin
        s_awready <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
        s_wready <= 1'b0;
      end else if (!w_held && !s_bvalid) begin
        s_wready <= 1'b1;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // read decode, unmapped words answer slverr
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_araddr >= OFS_QLEN && s_araddr < 8'hC0) begin
      rd_data = {16'h0000, q_len[3'((s_araddr - OFS_QLEN) >> 2)]};
    end else if (s_araddr >= OFS_QSTART && s_araddr < 8'h84) begin
      rd_data = q_start[4'((s_araddr - OFS_QSTART) >> 2)];
    end else if (s_araddr >= OFS_L2H && s_araddr < OFS_QSTART) begin
      rd_data = l2h[s_araddr[4:2]];
    end else if (s_araddr >= OFS_H2L && s_araddr < OFS_L2H) begin
      rd_data = h2l[s_araddr[4:2]];
    end else begin
      unique case (s_araddr)
        OFS_GSTAT: rd_data = {23'h000000, gstat};
        OFS_GACK: rd_data = 32'h0000_0000;
        OFS_GENERAL_CONFIG_ONE: rd_data = {26'h0000000, general_config_one};
        OFS_QMASK: rd_data = {23'h000000, qmask};
        OFS_HPMASK: rd_data = {23'h000000, hpmask};
        OFS_SYSMASK: rd_data = {27'h0000000, sys_mask};
        OFS_DROPCNT: rd_data = {16'h0000, drop_cnt};
        OFS_DROPTH: rd_data = {16'h0000, drop_th};
        default: rd_err = 1'b1;
      endcase
    end
    if (s_araddr[1:0] != 2'h0) begin
      rd_err = 1'b1;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_err ? 32'h0000_0000 : rd_data;
      s_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end else if (!s_rvalid) begin
      s_arready <= 1'b1;
    end
  end

  // host configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_config_one <= GENERAL_CONFIG_ONE_RESET;
      qmask <= 9'h000;
      hpmask <= 9'h000;
      sys_mask <= SYSMASK_RESET;
      drop_th <= 16'h0000;
    end else if (wr_do && !wr_err) begin
      unique case (aw_addr)
        OFS_GENERAL_CONFIG_ONE: general_config_one <= w_data[5:0];
        OFS_QMASK: qmask <= w_data[8:0];
        OFS_HPMASK: hpmask <= w_data[8:0];
        OFS_SYSMASK: sys_mask <= w_data[4:0];
        OFS_DROPTH: drop_th <= w_data[15:0];
        default: ;
      endcase
    end
  end

  // queue start and length registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        q_start[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < NUM_RING_QUEUES; i++) begin
        q_len[i] <= 16'h0000;
      end
    end else if (wr_do && !wr_err) begin
      if (aw_addr >= OFS_QSTART && aw_addr < 8'h84) begin
        q_start[hidx] <= w_data;
      end else if (aw_addr >= OFS_QLEN && aw_addr < 8'hC0) begin
        q_len[3'((aw_addr - OFS_QLEN) >> 2)] <= w_data[15:0];
      end
    end
  end

  // mailbox pages; each side writes only its own page
  assign loc_wr_l2h_status = loc_sel && loc_we && loc_addr == LOC_L2H;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < MBX_REGS; i++) begin
        h2l[i] <= 32'h0000_0000;
        l2h[i] <= 32'h0000_0000;
      end
    end else begin
      if (wr_do && !wr_err && aw_addr >= OFS_H2L && aw_addr < OFS_L2H) begin
        h2l[midx] <= w_data;
      end
      if (loc_sel && loc_we && loc_addr[4:3] == LOC_L2H[4:3]) begin
        l2h[loc_addr[2:0]] <= loc_wdata;
      end
    end
  end

  // local read port, registered; reading the fifo word pops it
  assign lf_pop = loc_sel && !loc_we && loc_addr == LOC_FIFO && lf_cnt != '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loc_rdata <= 32'h0000_0000;
    end else if (loc_sel && !loc_we) begin
      if (loc_addr == LOC_FIFO) begin
        loc_rdata <= (lf_cnt != '0) ? lf_mem[lf_rp] : 32'h0000_0000;
      end else if (loc_addr[4] == 1'b0) begin
        loc_rdata <= loc_addr[3] ? l2h[loc_addr[2:0]] : h2l[loc_addr[2:0]];
      end else begin
        loc_rdata <= 32'h0000_0000;
      end
    end
  end

  // local doorbell fifo; a full fifo drops the new doorbell
  // full test on the count width, the pointer width cannot hold the depth
  assign lf_push = wr_do && !wr_err && aw_addr == OFS_H2L && lf_cnt != (LPW+1)'(LFIFO_DEPTH);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_wp <= '0;
      lf_rp <= '0;
      lf_cnt <= '0;
    end else begin
      if (lf_push) begin
        lf_mem[lf_wp] <= {1'b1, GRP_SYS, 2'h0, 3'h0, 3'h0, 5'h10, w_data[15:0]};
        lf_wp <= (lf_wp == LPW'(LFIFO_DEPTH - 1)) ? '0 : lf_wp + 1'b1;
      end
      if (lf_pop) begin
        lf_rp <= (lf_rp == LPW'(LFIFO_DEPTH - 1)) ? '0 : lf_rp + 1'b1;
      end
      lf_cnt <= lf_cnt + (LPW+1)'(lf_push) - (LPW+1)'(lf_pop);
    end
  end

  // receive drop counter; host write clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_cnt <= 16'h0000;
    end else if (wr_do && !wr_err && aw_addr == OFS_DROPCNT) begin
      drop_cnt <= 16'h0000;
    end else if (rx_drop_pulse && drop_cnt != 16'hFFFF) begin
      drop_cnt <= drop_cnt + 16'h0001;
    end
  end

  // level history for early-warning edges, and local irq pin sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_th_d <= 1'b0;
      act_th_d <= 1'b0;
      local_irq_out_s1 <= 1'b0;
      local_irq_out_s2 <= 1'b0;
    end else begin
      data_th_d <= rx_data_over_th;
      act_th_d <= rx_action_over_th;
      local_irq_out_s1 <= local_irq_in;
      local_irq_out_s2 <= local_irq_out_s1;
    end
  end

  // system events, each gated by its mask
  always_comb begin
    sys_ev = 5'h00;
    sys_ev[SYS_MB] = loc_wr_l2h_status;
    sys_ev[SYS_RX_BUFFER_ACCESS_FAIL_FLAG] = rx_drop_pulse && drop_th != 16'h0000 && drop_cnt + 16'h0001 == drop_th;
    sys_ev[SYS_RX_DATA_EARLY_WARNING_FLAG] = rx_data_over_th && !data_th_d && !general_config_one[CONF_RX_BUFFER_IRQ_MASK];
    sys_ev[SYS_RX_ACTION_EARLY_WARNING_FLAG] = rx_action_over_th && !act_th_d && !general_config_one[CONF_RX_BUFFER_IRQ_MASK];
    sys_ev[SYS_PB] = wr_do && !strb_full;
    sys_ev = sys_ev & ~sys_mask;
  end

  // pending system vectors, new event beats the clear of its take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_pend <= 5'h00;
      mb_system_vector_a <= 16'h0000;
      pb_system_vector_a <= 16'h0000;
    end else begin
      sys_pend <= (sys_pend & ~sys_take) | sys_ev;
      if (sys_ev[SYS_MB]) begin
        mb_system_vector_a <= loc_wdata[15:0];
      end
      if (sys_ev[SYS_PB]) begin
        pb_system_vector_a <= {8'h00, aw_addr};
      end
    end
  end

  // pick the highest-indexed pending system flag
  always_comb begin
    sys_take = 5'h00;
    sys_vec = 32'h0000_0000;
    for (int i = 0; i < 5; i++) begin
      if (sys_pend[i]) begin
        sys_take = 5'h01 << i;
      end
    end
    sys_vec[VEC_VALID] = 1'b1;
    sys_vec[VEC_GRP_LSB +: 2] = GRP_SYS;
    sys_vec[VEC_Q_LSB +: 3] = general_config_one[CONF_SYSTEM_QUEUE_SELECT_LSB +: 3];
    sys_vec[VEC_SYS_LSB +: 5] = sys_take;
    if (sys_take[SYS_MB]) begin
      sys_vec[15:0] = mb_system_vector_a;
    end else if (sys_take[SYS_PB]) begin
      sys_vec[15:0] = pb_system_vector_a;
    end else if (sys_take[SYS_RX_BUFFER_ACCESS_FAIL_FLAG]) begin
      sys_vec[15:0] = drop_cnt;
    end
    if (!(wr_state == W_IDLE && !(src_valid && src_ready))) begin
      sys_take = 5'h00;
    end
  end

  // queue routing for source vectors
  always_comb begin
    ext_q = src_queue;
    if (src_vector[VEC_GRP_LSB +: 2] == GRP_CMD) begin
      ext_q = CMD_QUEUE;
    end else if (src_vector[VEC_GRP_LSB +: 2] == GRP_CHAN && src_queue < CMD_QUEUE && hpmask[src_queue]) begin
      ext_q = HP_QUEUE;
    end
  end
  assign take_src = wr_state == W_IDLE && src_valid && src_ready;
  assign take_sys = sys_take != 5'h00;

  // queue writer, one vector into system memory at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= W_IDLE;
      src_ready <= 1'b0;
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= 32'h0000_0000;
      mem_wr_data <= 32'h0000_0000;
      cur_q <= 4'h0;
    end else begin
      unique case (wr_state)
        W_IDLE: begin
          if (take_src || take_sys) begin
            cur_q <= take_src ? ext_q : {1'b0, general_config_one[CONF_SYSTEM_QUEUE_SELECT_LSB +: 3]};
            mem_wr_addr <= take_src ? q_start[ext_q] + {14'h0000, q_wptr[ext_q], 2'h0}
                                    : q_start[general_config_one[CONF_SYSTEM_QUEUE_SELECT_LSB +: 3]]
                                      + {14'h0000, q_wptr[general_config_one[CONF_SYSTEM_QUEUE_SELECT_LSB +: 3]], 2'h0};
            // subtype passes through untouched so its path bit survives
            mem_wr_data <= take_src ? {1'b1, src_vector[30:27], ext_q[2:0], src_vector[23:0]}
                                    : sys_vec;
            mem_wr_valid <= 1'b1;
            src_ready <= 1'b0;
            wr_state <= W_BUSY;
          end else begin
            src_ready <= sys_pend == 5'h00;
          end
        end
        W_BUSY: begin
          if (mem_wr_ready) begin
            mem_wr_valid <= 1'b0;
            wr_state <= W_IDLE;
          end
        end
      endcase
    end
  end

  // ring write pointers; a zero length behaves as one dword
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        q_wptr[i] <= 16'h0000;
      end
    end else if (wr_do && !wr_err && aw_addr >= OFS_QSTART && aw_addr < 8'h84) begin
      q_wptr[hidx] <= 16'h0000;
    end else if (wr_state == W_BUSY && mem_wr_ready) begin
      if (cur_q == CMD_QUEUE) begin
        q_wptr[cur_q] <= (q_wptr[cur_q] + 16'h0001 >= CMD_QUEUE_DWORDS) ? 16'h0000 : q_wptr[cur_q] + 16'h0001;
      end else begin
        q_wptr[cur_q] <= (q_wptr[cur_q] + 16'h0001 >= q_len[cur_q[2:0]]) ? 16'h0000 : q_wptr[cur_q] + 16'h0001;
      end
    end
  end

  // global status, sticky; a new vector beats the acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gstat <= 9'h000;
    end else begin
      gstat <= (gstat & ~((wr_do && !wr_err && aw_addr == OFS_GACK) ? w_data[8:0] : 9'h000))
               | ((wr_state == W_BUSY && mem_wr_ready) ? 9'(9'h001 << cur_q) : 9'h000);
    end
  end

  // interrupt pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      local_irq_out <= 1'b0;
      pci_irq_out <= 1'b0;
    end else begin
      local_irq_out <= lf_cnt != '0;
      pci_irq_out <= (|(gstat & ~qmask))
                     | (general_config_one[CONF_LFIFO_PCI] && lf_cnt != '0)
                     | (general_config_one[CONF_LOCAL_IRQ_OUT_BRIDGE] && local_irq_out_s2);
    end
  end

endmodule : mailbox_interrupt_queue_ctrl

// [src/mbx_irq_pkg.sv]
package mbx_irq_pkg;
  // register byte offsets, host side
  localparam logic [7:0] OFS_GSTAT = 8'h00;
  localparam logic [7:0] OFS_GACK = 8'h04;
  localparam logic [7:0] OFS_GENERAL_CONFIG_ONE = 8'h08;
  localparam logic [7:0] OFS_QMASK = 8'h0C;
  localparam logic [7:0] OFS_HPMASK = 8'h10;
  localparam logic [7:0] OFS_SYSMASK = 8'h14;
  localparam logic [7:0] OFS_DROPCNT = 8'h18;
  localparam logic [7:0] OFS_DROPTH = 8'h1C;
  localparam logic [7:0] OFS_H2L = 8'h20;
  localparam logic [7:0] OFS_L2H = 8'h40;
  localparam logic [7:0] OFS_QSTART = 8'h60;
  localparam logic [7:0] OFS_QLEN = 8'hA0;
  // local bus word indexes
  localparam logic [4:0] LOC_H2L = 5'h00;
  localparam logic [4:0] LOC_L2H = 5'h08;
  localparam logic [4:0] LOC_FIFO = 5'h10;
  // general_config_one fields
  localparam int CONF_SYSTEM_QUEUE_SELECT_LSB = 0;
  localparam int CONF_RX_BUFFER_IRQ_MASK = 3;
  localparam int CONF_LFIFO_PCI = 4;
  localparam int CONF_LOCAL_IRQ_OUT_BRIDGE = 5;
  localparam logic [5:0] GENERAL_CONFIG_ONE_RESET = 6'h00;
  localparam logic [4:0] SYSMASK_RESET = 5'h1F;
  // vector layout
  localparam int VEC_VALID = 31;
  localparam int VEC_GRP_LSB = 29;
  localparam int VEC_VECTOR_SUBTYPE_LSB = 27;
  localparam int VEC_Q_LSB = 24;
  localparam int VEC_SYS_LSB = 16;
  localparam logic [1:0] GRP_CMD = 2'h0;
  localparam logic [1:0] GRP_CHAN = 2'h1;
  localparam logic [1:0] GRP_PORT = 2'h2;
  localparam logic [1:0] GRP_SYS = 2'h3;
  // system vector flag indexes
  localparam int SYS_PB = 0;
  localparam int SYS_RX_ACTION_EARLY_WARNING_FLAG = 1;
  localparam int SYS_RX_DATA_EARLY_WARNING_FLAG = 2;
  localparam int SYS_RX_BUFFER_ACCESS_FAIL_FLAG = 3;
  localparam int SYS_MB = 4;
  // queues
  localparam int NUM_QUEUES = 9;
  localparam int NUM_RING_QUEUES = 8;
  localparam logic [3:0] HP_QUEUE = 4'h7;
  localparam logic [3:0] CMD_QUEUE = 4'h8;
  localparam logic [15:0] CMD_QUEUE_DWORDS = 16'h0200;
  localparam int MBX_REGS = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mbx_irq_pkg

// [tb/mbx_irq_chk.sv]
module mbx_irq_chk
  import mbx_irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register write channel
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  // local bus and sources
  input wire logic loc_sel,
  input wire logic loc_we,
  input wire logic [4:0] loc_addr,
  input wire logic src_valid,
  input wire logic src_ready,
  // queue writes and pins
  input wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  input wire logic [31:0] mem_wr_addr,
  input wire logic [31:0] mem_wr_data,
  input wire logic local_irq_out,
  input wire logic pci_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic popped;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // remembers a fifo pop so a falling local irq can be traced to it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      popped <= 1'b0;
    end else begin
      popped <= loc_sel && !loc_we && loc_addr == LOC_FIFO;
    end
  end
  // a stalled queue write must keep its whole payload
  sequence mem_stall;
    mem_wr_valid && !mem_wr_ready;
  endsequence
  sequence mem_hold;
    mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data);
  endsequence
  sequence sys_vec;
    mem_wr_valid && mem_wr_data[30:29] == GRP_SYS;
  endsequence
  chk_reset_quiet: assert property ($rose(aresetn) |-> !(pci_irq_out || local_irq_out || mem_wr_valid) [*2])
    else $error("output active right after reset");
  chk_mem_hold: assert property (mem_stall |=> mem_hold)
    else $error("queue write changed while stalled");
  chk_vec_marked: assert property (mem_wr_valid |-> mem_wr_data[VEC_VALID])
    else $error("vector top bit clear");
  chk_sys_layout: assert property (sys_vec |-> mem_wr_data[28:27] == 2'h0 && mem_wr_data[23:21] == 3'h0 && $onehot(mem_wr_data[20:16]))
    else $error("system vector layout bad");
  chk_src_to_mem: assert property (src_valid && src_ready |=> mem_wr_valid)
    else $error("taken vector not written");
  chk_partial_err: assert property (s_wvalid && s_wready && s_wstrb != 4'hF |-> ##[1:8] s_bvalid && s_bresp == RESP_SLVERR)
    else $error("partial write not refused");
  chk_bvalid_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped early");
  chk_lirq_pop: assert property ($fell(local_irq_out) |-> $past(popped))
    else $error("local irq fell without a pop");
endmodule : mbx_irq_chk

bind mailbox_interrupt_queue_ctrl mbx_irq_chk chk (.*);

// [tb/mbx_sysmem_model.sv]
module mbx_sysmem_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // queue write channel
  input wire logic mem_wr_valid,
  input wire logic [31:0] mem_wr_addr,
  input wire logic [31:0] mem_wr_data,
  output logic mem_wr_ready,
  // last accepted write
  output logic [31:0] last_addr,
  output logic [31:0] last_data,
  output int n_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  // random stalls, so the hold of a pending write is exercised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_wr_ready <= 1'b0;
      n_wr <= 0;
    end else begin
      mem_wr_ready <= ($urandom % 3) != 0;
      if (mem_wr_valid && mem_wr_ready) begin
        last_addr <= mem_wr_addr;
        last_data <= mem_wr_data;
        n_wr <= n_wr + 1;
      end
    end
  end
endmodule : mbx_sysmem_model

// [tb/mailbox_interrupt_queue_ctrl_tb_top.sv]
module mailbox_interrupt_queue_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mbx_irq_pkg::*;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, loc_sel, loc_we, src_valid, src_ready;
  logic rx_drop_pulse, rx_data_over_th, rx_action_over_th, local_irq_in, local_irq_out, pci_irq_out;
  logic mem_wr_valid, mem_wr_ready;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, loc_wdata, loc_rdata, src_vector, mem_wr_addr, mem_wr_data;
  logic [31:0] last_addr, last_data, v, s;
  logic [3:0] s_wstrb, src_queue;
  logic [1:0] s_bresp, s_rresp;
  logic [4:0] loc_addr;
  logic [8:0] hp, qm;
  logic [31:0] qbase [9];
  int wptr [9];
  int n_wr, nseen, failures, checks, sq, q;

  mailbox_interrupt_queue_ctrl #(.LFIFO_DEPTH(4)) dut (.*);
  mbx_sysmem_model mem (.*);

  // free-running bus clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // address and data offered together, released each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] st = 4'hF);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_awready) begin
        aw = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w && s_wready) begin
        w = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    while (!s_bvalid) @(posedge aclk);
    s_bready <= 1'b0;
    cmp("bresp", 32'(er), 32'(s_bresp));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    while (!s_rvalid) @(posedge aclk);
    s_rready <= 1'b0;
    cmp("rdata", e, s_rdata);
    cmp("rresp", 32'(er), 32'(s_rresp));
  endtask : rd

  task automatic lw(input logic [4:0] i, input logic [31:0] d);
    loc_sel <= 1'b1;
    loc_we <= 1'b1;
    loc_addr <= i;
    loc_wdata <= d;
    @(posedge aclk);
    loc_sel <= 1'b0;
    @(posedge aclk);
  endtask : lw

  task automatic lr(input logic [4:0] i, input logic [31:0] e);
    loc_sel <= 1'b1;
    loc_we <= 1'b0;
    loc_addr <= i;
    @(posedge aclk);
    loc_sel <= 1'b0;
    @(posedge aclk);
    cmp("loc_rdata", e, loc_rdata);
  endtask : lr

  // next queue write must land at the ring slot of queue qi
  task automatic ev(input int qi, input logic [31:0] d, input logic [31:0] m = '1);
    int t;
    t = 0;
    while (n_wr == nseen && t < 300) begin
      @(posedge aclk);
      t++;
    end
    // a vector that never arrives is a mismatch of its own
    if (t >= 300) failures++;
    nseen = n_wr;
    cmp("vec_addr", qbase[qi] + 32'(4 * wptr[qi]), last_addr);
    cmp("vec_data", d & m, last_data & m);
    wptr[qi] = (wptr[qi] + 1) % (qi == 8 ? 512 : 2);
  endtask : ev

  function automatic logic [31:0] fwd(input logic [31:0] x, input int qi);
    return {1'b1, x[30:27], 3'(qi), x[23:0]};
  endfunction : fwd

  // main sequence
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, loc_sel, loc_we, src_valid} = '0;
    {rx_drop_pulse, rx_data_over_th, rx_action_over_th, local_irq_in} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb, loc_addr, loc_wdata, src_vector, src_queue} = '0;
    void'($urandom(32'h35d5));
    tick(10);
    aresetn <= 1'b1;
    tick(3);
    cmp("pci_irq_out", 0, 32'(pci_irq_out));
    rd(OFS_GSTAT, 0);
    rd(OFS_SYSMASK, 32'(SYSMASK_RESET));
    rd(OFS_GENERAL_CONFIG_ONE, 32'(GENERAL_CONFIG_ONE_RESET));
    rd(8'hF0, 0, RESP_SLVERR);
    wr(OFS_GSTAT, 1, RESP_SLVERR);
    for (int i = 0; i < 9; i++) begin
      qbase[i] = 32'h1000_0000 + 32'(i) * 32'h400;
      wr(OFS_QSTART + 8'(4 * i), qbase[i]);
      if (i < 8)
        wr(OFS_QLEN + 8'(4 * i), 2);
    end
    for (int i = 0; i < 18; i++) begin
      v = $urandom;
      v[30:29] = 2'(i % 3);
      sq = $urandom % 7;
      hp = 9'($urandom);
      qm = 9'($urandom);
      q = v[30:29] == GRP_CMD ? 8 : (v[30:29] == GRP_CHAN && hp[sq]) ? 7 : sq;
      wr(OFS_HPMASK, 32'(hp));
      wr(OFS_QMASK, 32'(qm));
      src_vector <= v;
      src_queue <= 4'(sq);
      src_valid <= 1'b1;
      do @(posedge aclk); while (!src_ready);
      src_valid <= 1'b0;
      ev(q, fwd(v, q));
      tick(2);
      cmp("pci_irq_out", 32'(!qm[q]), 32'(pci_irq_out));
      rd(OFS_GSTAT, 32'(1) << q);
      wr(OFS_GACK, 32'(1) << q);
      rd(OFS_GSTAT, 0);
    end
    wr(OFS_QMASK, 0);
    wr(OFS_H2L + 8'h04, 32'hA5A5_0001);
    lr(LOC_H2L + 5'h01, 32'hA5A5_0001);
    s = $urandom;
    wr(OFS_H2L, s);
    tick(2);
    cmp("local_irq_out", 1, 32'(local_irq_out));
    lr(LOC_FIFO, 32'hE010_0000 | s[15:0]);
    tick(1);
    cmp("local_irq_out", 0, 32'(local_irq_out));
    wr(OFS_SYSMASK, 0);
    wr(OFS_GENERAL_CONFIG_ONE, 5);
    lw(LOC_L2H + 5'h07, ~s);
    rd(OFS_L2H + 8'h1C, ~s);
    lw(LOC_L2H, s);
    ev(5, 32'hE510_0000 | s[15:0]);
    rd(OFS_L2H, s);
    wr(OFS_QMASK, 32'h1FF, RESP_SLVERR, 4'h3);
    ev(5, 32'hE501_000C);
    rd(OFS_QMASK, 0);
    wr(OFS_DROPTH, 3);
    for (int i = 0; i < 3; i++) begin
      rx_drop_pulse <= 1'b1;
      @(posedge aclk);
      rx_drop_pulse <= 1'b0;
      @(posedge aclk);
    end
    ev(5, 32'hE508_0003);
    rd(OFS_DROPCNT, 3);
    rx_data_over_th <= 1'b1;
    ev(5, 32'hE504_0000, 32'hFFFF_0000);
    rx_action_over_th <= 1'b1;
    ev(5, 32'hE502_0000, 32'hFFFF_0000);
    {rx_data_over_th, rx_action_over_th} <= 2'b00;
    wr(OFS_GENERAL_CONFIG_ONE, 32'h0D);
    {rx_data_over_th, rx_action_over_th} <= 2'b11;
    tick(20);
    cmp("vector_count", 32'(nseen), 32'(n_wr));
    wr(OFS_GACK, 32'h1FF);
    tick(3);
    cmp("pci_irq_out", 0, 32'(pci_irq_out));
    wr(OFS_GENERAL_CONFIG_ONE, 32'h15);
    wr(OFS_H2L, s);
    tick(3);
    cmp("pci_irq_out", 1, 32'(pci_irq_out));
    lr(LOC_FIFO, 32'hE010_0000 | s[15:0]);
    tick(3);
    cmp("pci_irq_out", 0, 32'(pci_irq_out));
    wr(OFS_GENERAL_CONFIG_ONE, 32'h25);
    local_irq_in <= 1'b1;
    tick(6);
    cmp("pci_irq_out", 1, 32'(pci_irq_out));
    local_irq_in <= 1'b0;
    tick(6);
    cmp("pci_irq_out", 0, 32'(pci_irq_out));
    stop_test();
  end

  // cuts a hang short; the whole run needs well under this
  initial begin
    #100us;
    failures++;
    stop_test();
  end
endmodule : mailbox_interrupt_queue_ctrl_tb_top
